// [bench/sas_decoder_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// decoder and stack feed
// ****
module sas_decoder_model (
   input wire logic clk,
   output var logic exec,
   output var logic [3:0] alu_func,
   output var logic [3:0] shift_sel,
   output var logic use_alt,
   output var logic [15:0] alt_operand,
   output var logic top_load,
   output var logic [15:0] top_in,
   output var logic next_load,
   output var logic [15:0] next_in
);
   // idle decoder, alt source fixed
   initial begin
      {exec, alu_func, shift_sel, use_alt, top_load, top_in, next_load, next_in} = '0;
      alt_operand = 16'h7FFF;
   end
   // one op, fields held for its single edge
   task op(input [3:0] f, input [3:0] s, input u);
      @(posedge clk);
      exec <= 1'b1;
      alu_func <= f;
      shift_sel <= s;
      use_alt <= u;
      @(posedge clk);
      exec <= 1'b0;
   endtask
   // stack pop/push, data scrambled once released
   task ld(input [15:0] t, input [15:0] n);
      @(posedge clk);
      {top_load, next_load, top_in, next_in} <= {2'b11, t, n};
      @(posedge clk);
      {top_load, next_load, top_in, next_in} <= {2'b00, ~t, ~n};
   endtask
endmodule // sas_decoder_model
`default_nettype wire

// [bench/sas_stack_alu_shifter_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// datapath checks
// ****
module sas_alu_props (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic EXEC,
   input wire logic [3:0] ALU_FUNC,
   input wire logic [3:0] SHIFT_SEL,
   input wire logic USE_ALT_OPERAND,
   input wire logic WR,
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic [15:0] TOP,
   input wire logic [15:0] NEXT,
   input wire logic CARRY
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   // unshifted op on the second register
   wire plain = EXEC && !USE_ALT_OPERAND && SHIFT_SEL == 4'h0;
   chk_add_sum: assert property (plain && ALU_FUNC == 4'h8 |=>
      {CARRY, TOP} == {1'b0, $past(TOP)} + $past(NEXT)) else $error("add wrong");
   chk_sub_borrow: assert property (plain && ALU_FUNC == 4'hC |=>
      {CARRY, TOP} == {1'b0, $past(TOP)} + {1'b0, ~$past(NEXT)} + 17'h00001) else $error("sub wrong");
   chk_and_result: assert property (plain && ALU_FUNC == 4'h2 |=> TOP == ($past(TOP) & $past(NEXT)))
      else $error("and wrong");
   chk_bool_carry: assert property (EXEC && SHIFT_SEL == 4'h0 && ALU_FUNC inside {2, 3, 5, 6, 9, 11}
      |=> CARRY == $past(CARRY)) else $error("boolean moved carry");
   chk_sign_fill: assert property (EXEC && SHIFT_SEL == 4'h1 |=> TOP == 16'h0000 || TOP == 16'hFFFF)
      else $error("sign fill wrong");
   chk_top_only: assert property (EXEC && SHIFT_SEL < 4'h8 |=> $stable(NEXT))
      else $error("second register moved");
   chk_lower_left: assert property (EXEC && SHIFT_SEL == 4'h8 |=> NEXT == ($past(NEXT) << 1))
      else $error("second shift wrong");
   chk_logic_right: assert property (EXEC && SHIFT_SEL == 4'h6 |=> !CARRY && !TOP[15])
      else $error("logical right wrong");
   chk_carry_write: assert property (!EXEC && WR && ADDR == 4'h0 |=>
      {15'h0000, CARRY} == ($past(WDATA) & 16'h0001)) else $error("carry write lost");
endmodule // sas_alu_props
bind sas_stack_alu_shifter sas_alu_props i_props (.CLK(CLK), .RESET(RESET), .EXEC(EXEC), .ALU_FUNC(ALU_FUNC),
   .SHIFT_SEL(SHIFT_SEL), .USE_ALT_OPERAND(USE_ALT_OPERAND), .WR(WR), .ADDR(ADDR), .WDATA(WDATA),
   .TOP(TOP), .NEXT(NEXT), .CARRY(CARRY));
`default_nettype wire

// [bench/test_stack_alu_shifter.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// bench top
// ****
module test_stack_alu_shifter;
   logic CLK, RESET, WR, RD, ex, ua, tl, nl, cy;
   logic [3:0] ADDR, fn, sh;
   logic [15:0] WDATA, RDATA, alt, ti, ni, TOP, NEXT, t, n;
   logic [32:0] e;
   int fail_count, comparisons, i, j;
   sas_decoder_model i_dec (.clk(CLK), .exec(ex), .alu_func(fn), .shift_sel(sh), .use_alt(ua),
      .alt_operand(alt), .top_load(tl), .top_in(ti), .next_load(nl), .next_in(ni));
   sas_stack_alu_shifter i_dut (.CLK(CLK), .RESET(RESET), .EXEC(ex), .ALU_FUNC(fn), .SHIFT_SEL(sh),
      .USE_ALT_OPERAND(ua), .ALT_OPERAND(alt), .TOP_LOAD(tl), .TOP_IN(ti), .NEXT_LOAD(nl), .NEXT_IN(ni),
      .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TOP(TOP), .NEXT(NEXT), .CARRY(cy));
   always #2 CLK = ~CLK;
   // expected {carry, top, next}; unused function codes pass top
   function automatic [32:0] rf(input [3:0] f, s, input [15:0] a, y, m, input c);
      logic [15:0] z, q;
      logic k;
      {k, z, q} = {c, a, m};
      case (f)
         4'h2: z = a & y;
         4'h3: z = ~(a | y);
         4'h5: z = a | y;
         4'h6: z = ~(a & y);
         4'h9: z = a ^ y;
         4'hB: z = ~(a ^ y);
         4'h8: {k, z} = a + y;
         4'h7: {k, z} = a + y + c;
         4'hC: {k, z} = a + {1'b0, ~y} + 17'h00001;
         4'hD: {k, z} = a + {1'b0, ~y} + c;
         4'h4: {k, z} = y + {1'b0, ~a} + 17'h00001;
         4'hA: {k, z} = y + {1'b0, ~a} + c;
         default: ;
      endcase
      case (s)
         4'h1: z = {16{z[15]}};
         4'h2: {k, z} = {z, 1'b0};
         4'h3: {k, z} = {z, k};
         4'h4: {z, k} = {k, z[15:1], 1'b0};
         4'h5: {z, k} = {k, z};
         4'h6: {z, k} = {1'b0, z[15:1], 1'b0};
         4'h7: {z, k} = {z[15], z[15:1], z[15]};
         4'h8: q = {m[14:0], 1'b0};
         4'h9: q = {m[14:0], k};
         default: ;
      endcase
      return {k, z, q};
   endfunction
   task chk(input [15:0] g, input [15:0] x);
      comparisons++;
      if (g !== x) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask
   // bus cycles, one strobe cycle each
   task wr(input [3:0] a, input [15:0] d);
      @(posedge CLK);
      {WR, ADDR, WDATA} <= {1'b1, a, d};
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task rd(input [3:0] a, input [15:0] x);
      @(posedge CLK);
      {RD, ADDR} <= {1'b1, a};
      @(posedge CLK);
      RD <= 1'b0;
      #1 chk(RDATA, x);
      @(posedge CLK);
      #1 chk(RDATA, 16'h0000);
   endtask
   task finish_test;
      if (fail_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (100000) @(posedge CLK);
      fail_count++;
      finish_test;
   end
   // every function code against every shift code, carry preset to i[0] ^ j[1]
   initial begin
      {CLK, RESET, WR, RD, ADDR, WDATA, fail_count, comparisons} = {4'b0100, 20'h0, 64'h0};
      repeat (10) @(posedge CLK);
      RESET <= 1'b0;
      for (i = 0; i < 16; i++) begin
         for (j = 0; j < 16; j++) begin
            t = {i[3:0], j[3:0], 8'h81};
            n = 16'hFF7E ^ {j[3:0], 12'h000};
            e = rf(i[3:0], j[3:0], t, (i[0] & j[0]) ? 16'h7FFF : n, n, i[0] ^ j[1]);
            i_dec.ld(t, n);
            wr(4'h0, {15'h0000, i[0] ^ j[1]});
            i_dec.op(i[3:0], j[3:0], i[0] & j[0]);
            #1 chk(TOP, e[31:16]);
            chk(NEXT, e[15:0]);
            chk({15'h0000, cy}, {15'h0000, e[32]});
         end
      end
      rd(4'h0, {15'h0000, e[32]});
      wr(4'h1, 16'h0000);
      rd(4'h1, e[31:16]);
      rd(4'h2, e[15:0]);
      rd(4'hF, 16'h0000);
      finish_test;
   end
endmodule // test_stack_alu_shifter
`default_nettype wire

// [src/sas_consts.vh]
`ifndef SAS_CONSTS_VH
`define SAS_CONSTS_VH

// ****************************************
// register bus offsets
// ****************************************
`define SAS_ADDR_W 4
`define SAS_OFS_CONFIG 4'h0
`define SAS_OFS_TOP 4'h1
`define SAS_OFS_NEXT 4'h2
`define SAS_CARRY_BIT 0

// ****************************************
// reset values
// ****************************************
`define SAS_RST_WORD 16'h0000
`define SAS_RST_CARRY 1'h0

// ****************************************
// alu function field
// ****************************************
`define SAS_FN_AND 4'h2
`define SAS_FN_NOR 4'h3
`define SAS_FN_OR 4'h5
`define SAS_FN_NAND 4'h6
`define SAS_FN_XOR 4'h9
`define SAS_FN_XNOR 4'hB
`define SAS_FN_ADD 4'h8
`define SAS_FN_ADDC 4'h7
`define SAS_FN_SUB 4'hC
`define SAS_FN_SUBB 4'hD
`define SAS_FN_RSUB 4'h4
`define SAS_FN_RSUBB 4'hA

// ****************************************
// shift field
// ****************************************
`define SAS_SH_NONE 4'h0
`define SAS_SH_SIGN_EXTEND 4'h1
`define SAS_SH_LEFT 4'h2
`define SAS_SH_ROTATE_LEFT 4'h3
`define SAS_SH_RIGHT_FROM_CARRY 4'h4
`define SAS_SH_ROTATE_RIGHT 4'h5
`define SAS_SH_LOGICAL_RIGHT 4'h6
`define SAS_SH_ARITH_RIGHT 4'h7
`define SAS_SH_LOWER_LEFT 4'h8
`define SAS_SH_LOWER_ROTATE_LEFT 4'h9

`endif

// [src/sas_stack_alu_shifter.v]
// Summary of operation
// - top combines with operand, result into top
// - all single step operations take one cycle
// - function codes select six boolean operations
// - boolean operations ignore and keep carry
// - carry sits in config bit 0, read/write
// - add/subtract set carry; three variants use it
// - add sums inputs plus optional carry
// - subtract adds ones complement, carry 0 borrow
// - shift field picks one-bit shift before write-back
// - 32-bit form: top upper, second lower word
// - codes below eight touch top only
// - code 0000 passes result and alu carry, keeps second
// - code 0001 fills top with sign bit
// - code 0010 left shift, zero in, msb carry
// - code 0011 left shift, carry in, msb carry
// - code 0100 right shift, carry in, carry cleared
// - code 0101 right rotate through carry
// - code 0110 logical right shift, carry cleared
// - code 0111 arithmetic right, msb into carry
// - code 1000 shifts second left, zero in
// - code 1001 shifts second left, carry in
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "sas_consts.vh"

module sas_stack_alu_shifter (
   input wire CLK,
   input wire RESET,
   input wire EXEC,
   input wire [3:0] ALU_FUNC,
   input wire [3:0] SHIFT_SEL,
   input wire USE_ALT_OPERAND,
   input wire [15:0] ALT_OPERAND,
   input wire TOP_LOAD,
   input wire [15:0] TOP_IN,
   input wire NEXT_LOAD,
   input wire [15:0] NEXT_IN,
   input wire [3:0] ADDR,
   input wire [15:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [15:0] RDATA,
   output wire [15:0] TOP,
   output wire [15:0] NEXT,
   output wire CARRY
);

   // ****************************************
   // decode helpers
   // ****************************************
   // true for the functions that drive the adder
   function is_arith;
      input [3:0] fn;
      begin
         is_arith = (fn == `SAS_FN_ADD) || (fn == `SAS_FN_ADDC) || (fn == `SAS_FN_SUB) ||
            (fn == `SAS_FN_SUBB) || (fn == `SAS_FN_RSUB) || (fn == `SAS_FN_RSUBB);
      end
   endfunction

   // true for the six bitwise functions, which never touch the carry
   function is_bool;
      input [3:0] fn;
      begin
         is_bool = (fn == `SAS_FN_AND) || (fn == `SAS_FN_NOR) || (fn == `SAS_FN_OR) ||
            (fn == `SAS_FN_NAND) || (fn == `SAS_FN_XOR) || (fn == `SAS_FN_XNOR);
      end
   endfunction

   // ****************************************
   // state and intermediates
   // ****************************************
   // stored words and carry, with the next values the shift stage builds for them
   reg [15:0] top_r;
   reg [15:0] next_r;
   reg carry_flag_r;
   reg [15:0] top_nxt;
   reg [15:0] next_nxt;
   reg carry_flag_nxt;
   // alu operands and results, all combinational
   reg [15:0] alu_y;
   reg [15:0] add_a;
   reg [15:0] add_b;
   reg add_cin;
   wire [16:0] add_sum;
   reg [15:0] alu_z;
   reg alu_cy;

   // ****************************************
   // decoded controls
   // ****************************************
   // the adder result and carry are only used for the six arithmetic codes
   wire op_arith;
   // bitwise codes leave the carry alone, so no carry path is needed for them
   wire op_bool;
   // a carry write lands only while no operation runs in the same cycle
   wire cfg_write;
   // stack loads are the stack logic's moves between operations
   wire stack_idle;
   assign op_arith = is_arith(ALU_FUNC);
   assign op_bool = is_bool(ALU_FUNC);
   assign cfg_write = WR && (ADDR == `SAS_OFS_CONFIG);
   assign stack_idle = ~EXEC;

   // ****************************************
   // bitwise slices
   // ****************************************
   // one slice per bit; each slice offers all six bitwise results
   // costs a few more gates than a shared mux, but keeps each bit's path short
   wire [15:0] bit_and;
   wire [15:0] bit_nor;
   wire [15:0] bit_or;
   wire [15:0] bit_nand;
   wire [15:0] bit_xor;
   wire [15:0] bit_xnor;
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_slice
         assign bit_and[g] = top_r[g] & alu_y[g];
         assign bit_nor[g] = ~(top_r[g] | alu_y[g]);
         assign bit_or[g] = top_r[g] | alu_y[g];
         assign bit_nand[g] = ~(top_r[g] & alu_y[g]);
         assign bit_xor[g] = top_r[g] ^ alu_y[g];
         assign bit_xnor[g] = ~(top_r[g] ^ alu_y[g]);
      end
   endgenerate

   // ****************************************
   // alu stage
   // ****************************************
   // second operand: the second register unless the decoder picks another
   always @* begin
      alu_y = USE_ALT_OPERAND ? ALT_OPERAND : next_r;
   end

   // adder inputs; subtraction inverts the subtrahend
   // a plain subtract feeds carry-in 1 to finish the twos complement,
   // the borrow forms feed the stored carry, so carry 0 means borrow
   always @* begin
      add_a = top_r;
      add_b = alu_y;
      add_cin = 1'h0;
      case (ALU_FUNC)
         `SAS_FN_ADD: begin
            add_cin = 1'h0;
         end
         `SAS_FN_ADDC: begin
            add_cin = carry_flag_r;
         end
         `SAS_FN_SUB: begin
            add_b = ~alu_y;
            add_cin = 1'h1;
         end
         `SAS_FN_SUBB: begin
            add_b = ~alu_y;
            add_cin = carry_flag_r;
         end
         `SAS_FN_RSUB: begin
            add_a = alu_y;
            add_b = ~top_r;
            add_cin = 1'h1;
         end
         `SAS_FN_RSUBB: begin
            add_a = alu_y;
            add_b = ~top_r;
            add_cin = carry_flag_r;
         end
         default: begin
            add_cin = 1'h0;
         end
      endcase
   end

   // the 17th bit is the adder carry-out
   assign add_sum = {1'h0, add_a} + {1'h0, add_b} + {16'h0000, add_cin};

   // result and carry of the alu stage, before any shift
   always @* begin
      alu_cy = carry_flag_r;
      alu_z = top_r;
      if (op_arith) begin
         alu_z = add_sum[15:0];
         alu_cy = add_sum[16];
      end else if (op_bool) begin
         case (ALU_FUNC)
            `SAS_FN_AND: begin
               alu_z = bit_and;
            end
            `SAS_FN_NOR: begin
               alu_z = bit_nor;
            end
            `SAS_FN_OR: begin
               alu_z = bit_or;
            end
            `SAS_FN_NAND: begin
               alu_z = bit_nand;
            end
            `SAS_FN_XOR: begin
               alu_z = bit_xor;
            end
            `SAS_FN_XNOR: begin
               alu_z = bit_xnor;
            end
            default: begin
               alu_z = top_r;
            end
         endcase
      end else begin
         // unused codes pass top and keep the carry
         alu_z = top_r;
      end
   end

   // ****************************************
   // shift stage and write-back selection
   // ****************************************
   // shift sees this cycle's alu carry, not the stored one, since both land on one edge
   always @* begin
      top_nxt = top_r;
      next_nxt = next_r;
      carry_flag_nxt = carry_flag_r;
      if (EXEC) begin
         top_nxt = alu_z;
         next_nxt = next_r;
         carry_flag_nxt = alu_cy;
         case (SHIFT_SEL)
            // result straight through
            `SAS_SH_NONE: begin
               top_nxt = alu_z;
               next_nxt = next_r;
               carry_flag_nxt = alu_cy;
            end
            // sign of the result copied into every bit
            `SAS_SH_SIGN_EXTEND: begin
               top_nxt = {16{alu_z[15]}};
               next_nxt = next_r;
               carry_flag_nxt = alu_cy;
            end
            // left, zero in, msb out to carry
            `SAS_SH_LEFT: begin
               top_nxt = {alu_z[14:0], 1'h0};
               next_nxt = next_r;
               carry_flag_nxt = alu_z[15];
            end
            // left, alu carry in, msb out to carry
            `SAS_SH_ROTATE_LEFT: begin
               top_nxt = {alu_z[14:0], alu_cy};
               next_nxt = next_r;
               carry_flag_nxt = alu_z[15];
            end
            // right, alu carry in at the top, carry cleared
            `SAS_SH_RIGHT_FROM_CARRY: begin
               top_nxt = {alu_cy, alu_z[15:1]};
               next_nxt = next_r;
               carry_flag_nxt = 1'h0;
            end
            // right through the carry
            `SAS_SH_ROTATE_RIGHT: begin
               top_nxt = {alu_cy, alu_z[15:1]};
               next_nxt = next_r;
               carry_flag_nxt = alu_z[0];
            end
            // right, zero in, carry cleared
            `SAS_SH_LOGICAL_RIGHT: begin
               top_nxt = {1'h0, alu_z[15:1]};
               next_nxt = next_r;
               carry_flag_nxt = 1'h0;
            end
            // right, sign kept and copied into the carry
            `SAS_SH_ARITH_RIGHT: begin
               top_nxt = {alu_z[15], alu_z[15:1]};
               next_nxt = next_r;
               carry_flag_nxt = alu_z[15];
            end
            // second word left, zero in; top takes the plain result
            `SAS_SH_LOWER_LEFT: begin
               top_nxt = alu_z;
               next_nxt = {next_r[14:0], 1'h0};
               carry_flag_nxt = alu_cy;
            end
            // second word left, alu carry in
            `SAS_SH_LOWER_ROTATE_LEFT: begin
               top_nxt = alu_z;
               next_nxt = {next_r[14:0], alu_cy};
               carry_flag_nxt = alu_cy;
            end
            // wider 32-bit codes are not built; they fall back to no shift
            default: begin
               top_nxt = alu_z;
               next_nxt = next_r;
               carry_flag_nxt = alu_cy;
            end
         endcase
      end else if (stack_idle) begin
         // stack logic moves words only while no operation runs
         if (TOP_LOAD) begin
            top_nxt = TOP_IN;
         end
         if (NEXT_LOAD) begin
            next_nxt = NEXT_IN;
         end
         // software may set the carry; an executing operation wins over it
         if (cfg_write) begin
            carry_flag_nxt = WDATA[`SAS_CARRY_BIT];
         end
      end
   end

   // ****************************************
   // state registers
   // ****************************************
   // top word; shares its edge with second and carry so the op stays single cycle
   always @(posedge CLK) begin
      if (RESET) begin
         top_r <= `SAS_RST_WORD;
      end else begin
         top_r <= top_nxt;
      end
   end

   // second word, moved only by the lower-word shifts or a stack load
   always @(posedge CLK) begin
      if (RESET) begin
         next_r <= `SAS_RST_WORD;
      end else begin
         next_r <= next_nxt;
      end
   end

   // carry flag; written by the alu, the shift stage or a config write
   always @(posedge CLK) begin
      if (RESET) begin
         carry_flag_r <= `SAS_RST_CARRY;
      end else begin
         carry_flag_r <= carry_flag_nxt;
      end
   end

   // ****************************************
   // register read port
   // ****************************************
   // read data valid the cycle after the strobe; unmapped reads give zero
   always @(posedge CLK) begin
      if (RESET) begin
         RDATA <= 16'h0000;
      end else if (RD) begin
         case (ADDR)
            `SAS_OFS_CONFIG: RDATA <= {15'h0000, carry_flag_r};
            `SAS_OFS_TOP: RDATA <= top_r;
            `SAS_OFS_NEXT: RDATA <= next_r;
            default: RDATA <= 16'h0000;
         endcase
      end else begin
         RDATA <= 16'h0000;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // straight from the flip-flops, so the decoder sees settled words
   assign TOP = top_r;
   assign NEXT = next_r;
   assign CARRY = carry_flag_r;

endmodule // sas_stack_alu_shifter
`default_nettype wire

// [src/sas_unused_placeholder_none.v]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
